// file: pkg/apvd_map.svh
// register offsets, field positions, reset values and codes for the aux port / vco / divider bank
`ifndef APVD_MAP_SVH
`define APVD_MAP_SVH

`define APVD_IDX_AUX 6'h14
`define APVD_IDX_VCO 6'h15
`define APVD_IDX_DIV 6'h16
`define APVD_RST_AUX 24'h000220
`define APVD_RST_VCO 24'h0f48a0
`define APVD_RST_DIV 24'h0006c1
`define APVD_REG_W 24
`define APVD_AUX_SERIAL 0
`define APVD_AUX_VAL_HI 3
`define APVD_AUX_VAL_LO 1
`define APVD_AUX_LVL 4
`define APVD_AUX_SYNC 9
`define APVD_AUX_ROUTE_HI 11
`define APVD_AUX_ROUTE_LO 10
`define APVD_AUX_IDLE_HI 13
`define APVD_AUX_IDLE_LO 12
`define APVD_VCO_MCAL 0
`define APVD_VCO_CAP_HI 5
`define APVD_VCO_CAP_LO 1
`define APVD_VCO_BAND_HI 8
`define APVD_VCO_BAND_LO 6
`define APVD_VCO_MTUNE 9
`define APVD_VCO_SCALE 16
`define APVD_DIV_HI 5
`define APVD_DIV_LO 0
`define APVD_G1_HI 7
`define APVD_G1_LO 6
`define APVD_G2_HI 9
`define APVD_G2_LO 8
`define APVD_GSTAGE 10
`define APVD_DIV_MAX 6'h3e
`define APVD_ROUTE_NONE 2'h0
`define APVD_IDLE_HIZ 2'h0
`define APVD_IDLE_KEEP 2'h1
`define APVD_IDLE_HIGH 2'h2
`define APVD_IDLE_LOW 2'h3
`define APVD_MUX_LOCK 5'h01
`define APVD_PULSE_W 2'h1

`endif

// file: pkg/apvd_pkg.sv
// types shared by the aux port / vco / divider register bank
package apvd_pkg;
    typedef struct packed {
        logic serialMode;
        logic [2:0] staticValue;
        logic level33;
        logic phaseSyncEn;
        logic [1:0] muxRoute;
        logic [1:0] idleDrive;
    } apvd_aux_t;

    typedef struct packed {
        logic manualCal;
        logic [4:0] capSwitch;
        logic [2:0] coreBand;
        logic manualTune;
        logic autoScale;
    } apvd_vco_t;

    typedef struct packed {
        logic mute;
        logic [5:0] divRatio;
        logic [1:0] gainOut1;
        logic [1:0] gainOut2;
        logic stageMaxGain;
    } apvd_div_t;

    typedef struct packed {
        logic [2:0] pinOut;
        logic [2:0] pinOe;
    } apvd_pins_t;

    typedef enum logic [1:0] {
        APVD_IDLE,
        APVD_ACK
    } apvd_bus_state_t;
endpackage

// file: rtl/apvd_div_decode.sv
// decodes the raw divide code into an effective ratio and a mute flag
`timescale 1ns/1ps
`include "apvd_map.svh"
module apvd_div_decode #(
    parameter int W = 6
) (
    input wire logic [W-1:0] code, // raw divide field
    output logic [W-1:0] ratio, // effective ratio, 0 when muted
    output logic mute // output stages off
);
    always_comb begin
        mute = (code == '0);
        if (code > `APVD_DIV_MAX) begin
            ratio = `APVD_DIV_MAX;
        end else if (code == W'(1)) begin
            ratio = code;
        end else begin
            ratio = {code[W-1:1], 1'b0};
        end
    end
endmodule

// file: rtl/apvd_regs.sv
// aux port, manual vco and divider/gain register bank behind an avalon-mm slave
// What this block does
// - aux bit 0 set makes the three aux outputs a serial port, else static.
// - static mode drives each aux output from aux bits 3..1 when idle code is 1 (keep driven).
// - aux bit 4 picks static output level: clear 1.8 V, set 3.3 V.
// - aux bit 9 (default set) uses enable pin as phase-sync trigger, exact mode only.
// - aux bits 11..10 route the mux output: none, or output 0, 1, 2.
// - disabled port idle state: hi-z, keep driven, drive high, drive low.
// - vco bit 0 enables manual calibration; clear keeps automatic calibration.
// - manual sub-band from bits 8..6 (default 2), cap switch bits 5..1 (16).
// - vco bit 9 enables manual vco tuning; clear by default.
// - vco bit 16 (default set) auto-scales pump current.
// - divide code 0 mutes, 1 passes, even divides, odd rounds down, above 62 is 62.
// - two buffer gain fields; code 3 max, each lower code 3 dB less.
// - divider bit 10 set gives max stage gain, clear 3 dB less.
// - general output mux code 1 selects lock detect for routing to aux pin.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "apvd_map.svh"
module apvd_regs #(
    parameter int ADDR_W = 8
) (
    input wire logic clk, // 50 mhz clock
    input wire logic arst_n, // async reset, active low
    input wire logic [ADDR_W-1:0] avsAddress, // byte address
    input wire logic avsRead, // read request
    input wire logic avsWrite, // write request
    input wire logic [31:0] avsWritedata, // write data
    input wire logic [3:0] avsByteenable, // byte lanes
    output logic [31:0] avsReaddata, // read data
    output logic avsWaitrequest, // stall
    output logic [1:0] avsResponse, // 00 ok, 10 slave error
    input wire logic chipEnPin, // enable pin from outside
    input wire logic exactFreqEn, // exact frequency mode active
    input wire logic [4:0] generalOutputMuxSel, // mux selection code
    input wire logic lockDetect, // lock detect from pll
    input wire logic [2:0] serialPortOut, // aux serial engine outputs
    input wire logic [2:0] serialPortOe, // aux serial engine enables
    output apvd_pkg::apvd_pins_t auxPins, // aux output pins and enables
    output logic auxLevel33, // aux pad supply select
    output logic phaseSyncPulse, // phase sync trigger
    output apvd_pkg::apvd_vco_t vcoCtrl, // vco controls
    output apvd_pkg::apvd_div_t divCtrl // divider and gain controls
);
    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [`APVD_REG_W-1:0] auxReg;
    logic [`APVD_REG_W-1:0] vcoReg;
    logic [`APVD_REG_W-1:0] divReg;
    apvd_pkg::apvd_bus_state_t busState_reg;
    logic [ADDR_W-3:0] wordIdx;
    logic hit;
    logic [`APVD_REG_W-1:0] wmask;
    logic [`APVD_REG_W-1:0] rdSel;
    logic [5:0] ratio;
    logic muteDec;
    logic chipEnMeta_reg;
    logic chipEnSync_reg;
    logic chipEnPrev_reg;
    logic [2:0] serOutMeta_reg;
    logic [2:0] serOutSync_reg;
    logic [2:0] serOeMeta_reg;
    logic [2:0] serOeSync_reg;
    logic lockMeta_reg;
    logic lockSync_reg;
    logic [2:0] pinOut_next;
    logic [2:0] pinOe_next;
    logic muxSignal;

    assign wordIdx = avsAddress[ADDR_W-1:2];
    assign hit = (wordIdx == (ADDR_W-2)'(`APVD_IDX_AUX)) || (wordIdx == (ADDR_W-2)'(`APVD_IDX_VCO))
        || (wordIdx == (ADDR_W-2)'(`APVD_IDX_DIV));

    generate
        for (genvar b = 0; b < 3; b++) begin : g_mask
            assign wmask[b*8 +: 8] = {8{avsByteenable[b]}};
        end
    endgenerate

    always_comb begin
        rdSel = '0;
        if (wordIdx == (ADDR_W-2)'(`APVD_IDX_AUX)) begin
            rdSel = auxReg;
        end else if (wordIdx == (ADDR_W-2)'(`APVD_IDX_VCO)) begin
            rdSel = vcoReg;
        end else if (wordIdx == (ADDR_W-2)'(`APVD_IDX_DIV)) begin
            rdSel = divReg;
        end
    end

    // ----------------------------------------
    // avalon slave: one wait cycle, then answer
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busState_reg <= apvd_pkg::APVD_IDLE;
        end else begin
            unique case (busState_reg)
                apvd_pkg::APVD_IDLE: begin
                    if (avsRead || avsWrite) begin
                        busState_reg <= apvd_pkg::APVD_ACK;
                    end
                end
                apvd_pkg::APVD_ACK: begin
                    busState_reg <= apvd_pkg::APVD_IDLE;
                end
                default: begin
                    busState_reg <= apvd_pkg::APVD_IDLE;
                end
            endcase
        end
    end

    // waitrequest high by default so a new request is always stalled one cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            avsWaitrequest <= 1'b1;
        end else begin
            avsWaitrequest <= !(busState_reg == apvd_pkg::APVD_IDLE && (avsRead || avsWrite));
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            avsReaddata <= '0;
            avsResponse <= 2'h0;
        end else if (busState_reg == apvd_pkg::APVD_IDLE && (avsRead || avsWrite)) begin
            avsReaddata <= avsRead ? {8'h00, rdSel} : 32'h0;
            avsResponse <= hit ? 2'h0 : 2'h2;
        end
    end

    // writes commit on the same edge that the master sees waitrequest low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            auxReg <= `APVD_RST_AUX;
            vcoReg <= `APVD_RST_VCO;
            divReg <= `APVD_RST_DIV;
        end else if (busState_reg == apvd_pkg::APVD_ACK && avsWrite) begin
            if (wordIdx == (ADDR_W-2)'(`APVD_IDX_AUX)) begin
                auxReg <= (auxReg & ~wmask) | (avsWritedata[`APVD_REG_W-1:0] & wmask);
            end
            if (wordIdx == (ADDR_W-2)'(`APVD_IDX_VCO)) begin
                vcoReg <= (vcoReg & ~wmask) | (avsWritedata[`APVD_REG_W-1:0] & wmask);
            end
            if (wordIdx == (ADDR_W-2)'(`APVD_IDX_DIV)) begin
                divReg <= (divReg & ~wmask) | (avsWritedata[`APVD_REG_W-1:0] & wmask);
            end
        end
    end

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chipEnMeta_reg <= 1'b0;
            chipEnSync_reg <= 1'b0;
            chipEnPrev_reg <= 1'b0;
            lockMeta_reg <= 1'b0;
            lockSync_reg <= 1'b0;
            serOutMeta_reg <= '0;
            serOutSync_reg <= '0;
            serOeMeta_reg <= '0;
            serOeSync_reg <= '0;
        end else begin
            chipEnMeta_reg <= chipEnPin;
            chipEnSync_reg <= chipEnMeta_reg;
            chipEnPrev_reg <= chipEnSync_reg;
            lockMeta_reg <= lockDetect;
            lockSync_reg <= lockMeta_reg;
            serOutMeta_reg <= serialPortOut;
            serOutSync_reg <= serOutMeta_reg;
            serOeMeta_reg <= serialPortOe;
            serOeSync_reg <= serOeMeta_reg;
        end
    end

    // ----------------------------------------
    // phase sync trigger
    // ----------------------------------------
    // only meaningful with exact frequency mode, so gate it here
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phaseSyncPulse <= 1'b0;
        end else begin
            phaseSyncPulse <= auxReg[`APVD_AUX_SYNC] && exactFreqEn
                && chipEnSync_reg && !chipEnPrev_reg;
        end
    end

    // ----------------------------------------
    // aux port pins
    // ----------------------------------------
    // other mux codes are not modelled; only lock detect reaches the pins
    assign muxSignal = (generalOutputMuxSel == `APVD_MUX_LOCK) ? lockSync_reg : 1'b0;

    always_comb begin
        pinOut_next = auxPins.pinOut;
        pinOe_next = 3'h7;
        if (auxReg[`APVD_AUX_SERIAL]) begin
            pinOut_next = serOutSync_reg;
            pinOe_next = serOeSync_reg;
        end else begin
            pinOut_next = auxReg[`APVD_AUX_VAL_HI:`APVD_AUX_VAL_LO];
            unique case (auxReg[`APVD_AUX_IDLE_HI:`APVD_AUX_IDLE_LO])
                `APVD_IDLE_HIZ: pinOe_next = 3'h0;
                `APVD_IDLE_KEEP: pinOe_next = 3'h7;
                `APVD_IDLE_HIGH: pinOut_next = 3'h7;
                `APVD_IDLE_LOW: pinOut_next = 3'h0;
            endcase
        end
        if (auxReg[`APVD_AUX_ROUTE_HI:`APVD_AUX_ROUTE_LO] != `APVD_ROUTE_NONE) begin
            pinOut_next[auxReg[`APVD_AUX_ROUTE_HI:`APVD_AUX_ROUTE_LO] - 2'h1] = muxSignal;
            pinOe_next[auxReg[`APVD_AUX_ROUTE_HI:`APVD_AUX_ROUTE_LO] - 2'h1] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            auxPins <= '0;
            auxLevel33 <= 1'b0;
        end else begin
            auxPins.pinOut <= pinOut_next;
            auxPins.pinOe <= pinOe_next;
            auxLevel33 <= auxReg[`APVD_AUX_LVL];
        end
    end

    // ----------------------------------------
    // vco and divider controls
    // ----------------------------------------
    apvd_div_decode #(
        .W(6)
    ) u_div (
        .code(divReg[`APVD_DIV_HI:`APVD_DIV_LO]),
        .ratio(ratio),
        .mute(muteDec)
    );

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            vcoCtrl <= '0;
        end else begin
            vcoCtrl.manualCal <= vcoReg[`APVD_VCO_MCAL];
            vcoCtrl.capSwitch <= vcoReg[`APVD_VCO_CAP_HI:`APVD_VCO_CAP_LO];
            vcoCtrl.coreBand <= vcoReg[`APVD_VCO_BAND_HI:`APVD_VCO_BAND_LO];
            vcoCtrl.manualTune <= vcoReg[`APVD_VCO_MTUNE];
            vcoCtrl.autoScale <= vcoReg[`APVD_VCO_SCALE];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            divCtrl <= '0;
        end else begin
            divCtrl.mute <= muteDec;
            divCtrl.divRatio <= ratio;
            divCtrl.gainOut1 <= divReg[`APVD_G1_HI:`APVD_G1_LO];
            divCtrl.gainOut2 <= divReg[`APVD_G2_HI:`APVD_G2_LO];
            divCtrl.stageMaxGain <= divReg[`APVD_GSTAGE];
        end
    end
endmodule

// file: verif/apvd_regs_assertions.sv
// port-level assertion checker for the aux port / vco / divider register bank
`timescale 1ns/1ps
module apvd_regs_assertions #(
    parameter int ADDR_W = 8
) (
    input wire logic clk, // clock
    input wire logic arst_n, // async reset, active low
    input wire logic [ADDR_W-1:0] avsAddress, // byte address
    input wire logic avsRead, // read request
    input wire logic avsWrite, // write request
    input wire logic [31:0] avsWritedata, // write data
    input wire logic [3:0] avsByteenable, // byte lanes
    input wire logic [31:0] avsReaddata, // read data
    input wire logic avsWaitrequest, // stall
    input wire logic [1:0] avsResponse, // response code
    input wire logic exactFreqEn, // exact mode
    input wire logic auxLevel33, // pad level
    input wire logic phaseSyncPulse, // sync trigger
    input wire apvd_pkg::apvd_vco_t vcoCtrl, // vco controls
    input wire apvd_pkg::apvd_div_t divCtrl // divider controls
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    logic wrDone;
    logic [5:0] idx;
    assign wrDone = avsWrite && !avsWaitrequest && avsByteenable[0];
    assign idx = avsAddress[7:2];
    // ----------------------------------------
    // bus handshake
    // ----------------------------------------
    AST_WAIT_ONE: assert property (!avsWaitrequest |=> avsWaitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_ANSWER: assert property ((avsRead || avsWrite) && avsWaitrequest |-> ##[1:2] !avsWaitrequest)
        else $error("request not answered in time");
    AST_HI_ZERO: assert property (!avsWaitrequest |-> avsReaddata[31:24] == 8'h00)
        else $error("read data top byte not zero");
    AST_UNMAPPED: assert property (avsRead && !avsWaitrequest && (idx < 6'h14 || idx > 6'h16)
        |-> avsResponse == 2'h2 && avsReaddata == 32'h0)
        else $error("unmapped read not refused");
    // ----------------------------------------
    // control outputs follow committed writes; sync pulse needs exact mode, lasts one cycle
    // ----------------------------------------
    AST_LEVEL: assert property (wrDone && idx == 6'h14 |-> ##2 auxLevel33 == $past(avsWritedata[4], 2))
        else $error("aux level not taken from write");
    AST_CAL: assert property (wrDone && idx == 6'h15 && avsByteenable[1] |-> ##2
        vcoCtrl.manualCal == $past(avsWritedata[0], 2) && vcoCtrl.coreBand == $past(avsWritedata[8:6], 2))
        else $error("manual calibration fields wrong");
    AST_TUNE: assert property (wrDone && idx == 6'h15 && avsByteenable[2:1] == 2'h3 |-> ##2
        vcoCtrl.manualTune == $past(avsWritedata[9], 2) && vcoCtrl.autoScale == $past(avsWritedata[16], 2))
        else $error("tune or scale bit wrong");
    AST_GAIN: assert property (wrDone && idx == 6'h16 && avsByteenable[1] |-> ##2
        divCtrl.gainOut1 == $past(avsWritedata[7:6], 2) && divCtrl.gainOut2 == $past(avsWritedata[9:8], 2)
        && divCtrl.stageMaxGain == $past(avsWritedata[10], 2))
        else $error("gain fields wrong");
    AST_MUTE: assert property (wrDone && idx == 6'h16 |-> ##2
        divCtrl.mute == ($past(avsWritedata[5:0], 2) == 6'h00) && divCtrl.divRatio <= 6'h3e
        && (divCtrl.divRatio[0] == 1'b0 || divCtrl.divRatio == 6'h01))
        else $error("divider mute or ratio wrong");
    AST_PULSE: assert property (phaseSyncPulse |-> $past(exactFreqEn) ##1 !phaseSyncPulse)
        else $error("phase sync pulse wrong");
endmodule

bind apvd_regs apvd_regs_assertions #(.ADDR_W(ADDR_W)) u_chk (.clk, .arst_n, .avsAddress, .avsRead, .avsWrite,
    .avsWritedata, .avsByteenable, .avsReaddata, .avsWaitrequest, .avsResponse, .exactFreqEn, .auxLevel33,
    .phaseSyncPulse, .vcoCtrl, .divCtrl);

// file: verif/apvd_host.sv
// host model that issues avalon-mm transfers to the register bank
`timescale 1ns/1ps
module apvd_host (
    input wire logic clk, // clock
    input wire logic avsWaitrequest, // stall from slave
    input wire logic [31:0] avsReaddata, // read data
    input wire logic [1:0] avsResponse, // response code
    output logic [7:0] avsAddress, // byte address
    output logic avsRead, // read request
    output logic avsWrite, // write request
    output logic [31:0] avsWritedata, // write data
    output logic [3:0] avsByteenable // byte lanes
);
    initial begin
        avsAddress = 8'h00;
        avsRead = 1'b0;
        avsWrite = 1'b0;
        avsWritedata = 32'h0;
        avsByteenable = 4'h0;
    end
    // enter just after a rising edge; returns one edge after release
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                        output logic [31:0] q, output logic [1:0] r);
        avsAddress <= a;
        avsWritedata <= d;
        avsByteenable <= be;
        avsWrite <= wr;
        avsRead <= !wr;
        @(posedge clk);
        while (avsWaitrequest !== 1'b0) @(posedge clk);
        q = avsReaddata;
        r = avsResponse;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        // stale data must not look valid after release
        avsWritedata <= ~d;
        @(posedge clk);
    endtask
endmodule

// file: verif/tb_aux_port_vco_divider_regs.sv
// self-checking bench for the aux port, vco and divider register bank
`timescale 1ns/1ps
`include "apvd_map.svh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin miscompares++; \
    $display("unexpected %s exp %h got %h", n, e, s); end end
module tb_aux_port_vco_divider_regs;
    logic clk, arst_n, chipEnPin, exactFreqEn, lockDetect;
    logic [4:0] generalOutputMuxSel;
    logic [2:0] serialPortOut, serialPortOe;
    logic [7:0] avsAddress;
    logic avsRead, avsWrite, avsWaitrequest, auxLevel33, phaseSyncPulse;
    logic [31:0] avsWritedata, avsReaddata, q, d;
    logic [3:0] avsByteenable, be;
    logic [1:0] avsResponse, r;
    apvd_pkg::apvd_pins_t auxPins;
    apvd_pkg::apvd_vco_t vcoCtrl;
    apvd_pkg::apvd_div_t divCtrl;
    logic [23:0] m [3];
    int miscompares, comparisons, i, pulses;
    apvd_regs u_dut (.clk, .arst_n, .avsAddress, .avsRead, .avsWrite, .avsWritedata, .avsByteenable,
        .avsReaddata, .avsWaitrequest, .avsResponse, .chipEnPin, .exactFreqEn, .generalOutputMuxSel,
        .lockDetect, .serialPortOut, .serialPortOe, .auxPins, .auxLevel33, .phaseSyncPulse, .vcoCtrl, .divCtrl);
    apvd_host u_host (.clk, .avsWaitrequest, .avsReaddata, .avsResponse, .avsAddress, .avsRead, .avsWrite,
        .avsWritedata, .avsByteenable);
    // ----------------------------------------
    // expectations
    // ----------------------------------------
    function automatic apvd_pkg::apvd_vco_t vco_exp(input logic [23:0] v);
        return {v[0], v[5:1], v[8:6], v[9], v[16]};
    endfunction
    function automatic apvd_pkg::apvd_div_t div_exp(input logic [23:0] v);
        logic [5:0] c;
        c = v[5:0];
        if (c > 6'h3e) c = 6'h3e;
        else if (c > 6'h01) c[0] = 1'b0;
        return {v[5:0] == 6'h00, c, v[7:6], v[9:8], v[10]};
    endfunction
    // serial mode is only checked with routing off
    function automatic apvd_pkg::apvd_pins_t aux_exp(input logic [23:0] v);
        apvd_pkg::apvd_pins_t p;
        if (v[0]) return {serialPortOut, serialPortOe};
        case (v[13:12])
            2'h0: p = {3'h0, 3'h0};
            2'h1: p = {v[3:1], 3'h7};
            2'h2: p = {3'h7, 3'h7};
            default: p = {3'h0, 3'h7};
        endcase
        if (v[11:10] != 2'h0) begin
            p.pinOut[v[11:10] - 2'h1] = lockDetect && generalOutputMuxSel == 5'h01;
            p.pinOe[v[11:10] - 2'h1] = 1'b1;
        end
        return p;
    endfunction
    task automatic wreg(input int k, input logic [23:0] v, input logic [3:0] lanes);
        u_host.xfer(1'b1, 8'(8'h50 + 4 * k), {8'h00, v}, lanes, q, r);
        for (int b = 0; b < 3; b++) if (lanes[b]) m[k][b*8 +: 8] = v[b*8 +: 8];
    endtask
    task automatic check_all;
        apvd_pkg::apvd_pins_t p;
        for (int k = 0; k < 3; k++) begin
            u_host.xfer(1'b0, 8'(8'h50 + 4 * k), 32'h0, 4'hf, q, r);
            `CHK("readback", {8'h00, m[k]}, q)
            `CHK("response", 2'h0, r)
        end
        `CHK("vcoCtrl", vco_exp(m[1]), vcoCtrl)
        `CHK("divCtrl", div_exp(m[2]), divCtrl)
        `CHK("auxLevel33", m[0][4], auxLevel33)
        p = aux_exp(m[0]);
        `CHK("pinOe", p.pinOe, auxPins.pinOe)
        `CHK("pinOut", p.pinOut & p.pinOe, auxPins.pinOut & auxPins.pinOe)
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // clock, watchdog, tests
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #(20 * 6000);
        miscompares++;
        report_and_stop;
    end
    initial begin
        {arst_n, chipEnPin, exactFreqEn, lockDetect, generalOutputMuxSel, serialPortOut, serialPortOe} = '0;
        m[0] = `APVD_RST_AUX;
        m[1] = `APVD_RST_VCO;
        m[2] = `APVD_RST_DIV;
        d = $urandom(38);
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        check_all;
        for (int n = 0; n < 48; n++) begin
            d = $urandom;
            i = n % 3;
            // divider corner codes first: 0, 1, 2, 3, 60, 61, 62, 63
            if (i == 2 && n < 24) d[5:0] = 6'(n / 3 < 4 ? n / 3 : 56 + n / 3);
            if (i == 0 && d[0]) d[11:10] = 2'h0;
            be = (n < 12 || i == 0) ? 4'hf : 4'($urandom);
            lockDetect <= $urandom;
            generalOutputMuxSel <= 5'($urandom % 3);
            serialPortOut <= $urandom;
            serialPortOe <= $urandom;
            wreg(i, d[23:0], be);
            check_all;
        end
        u_host.xfer(1'b1, 8'h5c, 32'h00ffffff, 4'hf, q, r);
        u_host.xfer(1'b0, 8'h5c, 32'h0, 4'hf, q, r);
        `CHK("unmapped data", 32'h0, q)
        `CHK("unmapped resp", 2'h2, r)
        check_all;
        for (int k = 0; k < 3; k++) begin
            wreg(0, 24'(k != 2) << 9, 4'hf);
            exactFreqEn <= (k != 1);
            repeat (4) @(posedge clk);
            pulses = 0;
            chipEnPin <= 1'b1;
            repeat (8) begin
                @(posedge clk);
                pulses += (phaseSyncPulse === 1'b1);
            end
            chipEnPin <= 1'b0;
            `CHK("pulses", 32'(k == 0), pulses)
        end
        report_and_stop;
    end
endmodule
